// *** core/adcc_cfg.svh ***
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// Register offsets on the plain register port
`define ADCC_OFS_CTRL      3'h0
`define ADCC_OFS_RES_HIGH  3'h1
`define ADCC_OFS_RES_LOW   3'h2
`define ADCC_OFS_IRQ_STAT  3'h3
`define ADCC_OFS_IRQ_MASK  3'h4

// Control register field positions
`define ADCC_CTRL_TRK_HI   7
`define ADCC_CTRL_TRK_LO   6
`define ADCC_CTRL_DONE     5
`define ADCC_CTRL_BUSY     4
`define ADCC_CTRL_STM_HI   3
`define ADCC_CTRL_STM_LO   2
`define ADCC_CTRL_WIN      1
`define ADCC_CTRL_LJST     0

// Interrupt status and mask bit positions
`define ADCC_IRQ_DONE      0
`define ADCC_IRQ_WIN       1
`define ADCC_IRQ_BUSYFALL  2

// Reset values
`define ADCC_CTRL_RST      8'h00
`define ADCC_MASK_RST      3'h0

// Timing counts in converter clock periods
`define ADCC_TRACK_CLKS    3
`define ADCC_CONV_CLKS     11

`endif

// *** core/adcc_pkg.sv ***
package adcc_pkg;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } adcc_bus_req_s;

  // Result and window verdict from the analog core
  typedef struct packed {
    logic [9:0] data;
    logic       window_hit;
  } adcc_core_res_s;

  // Trigger selection codes shared by tracking and start modes
  typedef enum logic [1:0] {
    ADCC_SRC_SW   = 2'b00,
    ADCC_SRC_TMR3 = 2'b01,
    ADCC_SRC_EXT  = 2'b10,
    ADCC_SRC_TMR2 = 2'b11
  } adcc_src_e;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ADCC_IDLE  = 2'b00,
    ADCC_TRACK = 2'b01,
    ADCC_CONV  = 2'b10
  } adcc_state_e;

endpackage

// *** core/adcc_sar_div.sv ***
module adcc_sar_div #(
  parameter int DIV = 4
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Control
  input  wire logic restart,
  // Converter clock enable
  output logic      sar_tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Restart aligns a phase to a whole converter period
  assign sar_tick = (cnt_q == LAST);
  assign cnt_d    = (restart || cnt_q == LAST) ? '0 : cnt_q + CW'(1);

  ////////////////////////////////////////////////////////////////////////
  // Divider counter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// *** core/adcc_ctrl.sv ***
// Behaviour
// RL1 - Tracking mode 11: timer 2 overflow starts tracking for three converter clocks.
// RL2 - Tracking mode 00: writing one to busy starts three-clock tracking.
// RL3 - Tracking mode 01: timer 3 overflow starts three-clock tracking.
// RL4 - Tracking mode 10: input tracked only while external start pin is low.
// RL5 - Conversion-complete flag, bit five, sets when a conversion finishes.
// RL6 - Software clears the conversion-complete flag; hardware never clears it.
// RL7 - Busy bit, bit four, reads one while a conversion is in progress.
// RL8 - Busy reads zero after conversion ends and after reset.
// RL9 - Falling edge of busy raises an interrupt request when enabled.
// RL10 - Writing zero to busy does nothing; one starts only in start mode 00.
// RL11 - Start mode, bits three to two, value 00: software write starts conversion.
// RL12 - Start mode 01: every timer 3 overflow starts a conversion. The code drops overflows that come during a conversion.
// RL13 - Start mode 11: every timer 2 overflow starts a conversion. The code drops overflows that come during a conversion.
// RL14 - Start mode 10: every rising edge of external start pin starts one. The code drops edges that come during a conversion.
// RL15 - Window-compare flag, bit one, sets when the result matches the window.
// RL16 - Software clears the window-compare flag; hardware leaves it set.
// RL17 - Justify bit zero clear: result right-justified across high and low bytes.
// RL18 - Justify bit set: result left-justified, unused low bits read zero.
`include "adcc_cfg.svh"

module adcc_ctrl #(
  parameter int SAR_DIV     = 4,
  parameter int TRACK_CLKS  = `ADCC_TRACK_CLKS,
  parameter int CONV_CLKS   = `ADCC_CONV_CLKS
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // Register port
  input  wire adcc_pkg::adcc_bus_req_s bus_req,
  output logic [7:0]                  reg_rdata,
  // Start sources
  input  wire logic                   tmr2_ovf,
  input  wire logic                   tmr3_ovf,
  input  wire logic                   ext_conv_start_in,
  // Analog core
  input  wire adcc_pkg::adcc_core_res_s core_res,
  output logic                        core_track,
  output logic                        core_convert,
  // Interrupt
  output logic                        conv_irq
);

  import adcc_pkg::*;

  // Four bits cover phases of up to sixteen converter clocks
  localparam int CNT_W = 4;
  // Last phase indices; the phase counter runs from zero
  localparam logic [CNT_W-1:0] TRACK_LAST = CNT_W'(TRACK_CLKS - 1);
  localparam logic [CNT_W-1:0] CONV_LAST  = CNT_W'(CONV_CLKS - 1);

  ////////////////////////////////////////////////////////////////////////
  // Trigger selector, shared by the tracking and start decoders
  function automatic logic sel_trigger(input logic [1:0] mode,
                                       input logic       sw,
                                       input logic       t3,
                                       input logic       ext,
                                       input logic       t2);
    logic hit;
    hit = 1'b0;
    unique case (adcc_src_e'(mode))
      ADCC_SRC_SW:   hit = sw;
      ADCC_SRC_TMR3: hit = t3;
      ADCC_SRC_EXT:  hit = ext;
      ADCC_SRC_TMR2: hit = t2;
    endcase
    return hit;
  endfunction

  // Places the ten-bit result as a high and low byte pair
  function automatic logic [15:0] justify(input logic       left,
                                          input logic [9:0] res);
    // Unused bits fill with zero on either side
    return left ? {res, 6'h00} : {6'h00, res};
  endfunction

  // True when a strobe targets the given register offset
  function automatic logic at_reg(input logic       strobe,
                                  input logic [2:0] addr,
                                  input logic [2:0] ofs);
    return strobe && (addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  adcc_state_e      state_q;
  adcc_state_e      state_d;
  logic [CNT_W-1:0] phase_q;
  logic [CNT_W-1:0] phase_d;
  logic             pend_q;
  logic             pend_d;
  logic             busy_prev_q;
  logic             ext_prev_q;
  logic [1:0]       trk_mode_q;
  logic [1:0]       start_mode_q;
  logic             done_q;
  logic             done_d;
  logic             win_q;
  logic             win_d;
  logic             ljst_q;
  logic [9:0]       result_q;
  logic [2:0]       irq_stat_q;
  logic [2:0]       irq_stat_d;
  logic [2:0]       irq_mask_q;
  logic [7:0]       rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  logic ctrl_wr;
  logic mask_wr;
  logic stat_rd;
  logic sw_start;

  // Unmapped offsets match nothing, so writes there are dropped
  assign ctrl_wr  = at_reg(bus_req.wr, bus_req.addr, `ADCC_OFS_CTRL);
  assign mask_wr  = at_reg(bus_req.wr, bus_req.addr, `ADCC_OFS_IRQ_MASK);
  assign stat_rd  = at_reg(bus_req.rd, bus_req.addr, `ADCC_OFS_IRQ_STAT);
  // A one to busy counts as a start request only in start mode 00
  assign sw_start = ctrl_wr && bus_req.wdata[`ADCC_CTRL_BUSY];  // RL10

  ////////////////////////////////////////////////////////////////////////
  // Event decode
  logic ext_rise;
  logic start_evt;
  logic track_evt;
  logic trk_pin_mode;
  logic [1:0] start_mode_eff;
  logic [1:0] trk_mode_eff;

  // A control write acts with the modes it writes, so one write can pick a mode and start
  assign start_mode_eff = ctrl_wr ? bus_req.wdata[`ADCC_CTRL_STM_HI:`ADCC_CTRL_STM_LO]
                                  : start_mode_q;
  assign trk_mode_eff   = ctrl_wr ? bus_req.wdata[`ADCC_CTRL_TRK_HI:`ADCC_CTRL_TRK_LO]
                                  : trk_mode_q;
  // Pin is synchronous to ref_clk, so a plain previous-value compare is enough
  assign ext_rise     = ext_conv_start_in && !ext_prev_q;  // RL14
  // Start sources per start mode; external edge only in mode 10
  assign start_evt    = sel_trigger(start_mode_eff, sw_start, tmr3_ovf,
                                    ext_rise, tmr2_ovf);  // RL10 RL11 RL12 RL13 RL14
  // Tracking sources per tracking mode; mode 10 is level driven, no event
  assign track_evt    = sel_trigger(trk_mode_eff, sw_start, tmr3_ovf,
                                    1'b0, tmr2_ovf);  // RL1 RL2 RL3
  // Pin tracking mode bypasses the timed tracking phase
  assign trk_pin_mode = (trk_mode_eff == ADCC_SRC_EXT);

  ////////////////////////////////////////////////////////////////////////
  // Converter clock enable; restarts when a phase opens
  logic sar_tick;
  logic phase_open;

  adcc_sar_div #(
    .DIV      (SAR_DIV)
  ) u_sar_div (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .restart  (phase_open),
    .sar_tick (sar_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  logic track_end;
  logic conv_end;

  assign track_end = (state_q == ADCC_TRACK) && sar_tick && (phase_q == TRACK_LAST);
  assign conv_end  = (state_q == ADCC_CONV) && sar_tick && (phase_q == CONV_LAST);

  always_comb begin
    state_d    = state_q;
    pend_d     = pend_q;
    phase_d    = sar_tick ? phase_q + CNT_W'(1) : phase_q;
    phase_open = 1'b0;
    unique case (state_q)
      ADCC_IDLE: begin
        phase_d = '0;
        if (start_evt && trk_pin_mode) begin
          // Pin already did the tracking; convert right away
          state_d    = ADCC_CONV;  // RL4
          phase_open = 1'b1;
        end else if (start_evt || track_evt) begin
          state_d    = ADCC_TRACK;  // RL1 RL2 RL3
          // A track-only event leaves pend clear, so tracking ends in idle
          pend_d     = start_evt;
          phase_open = 1'b1;
        end
      end
      ADCC_TRACK: begin
        if (start_evt) begin
          pend_d = 1'b1;
        end
        if (track_end) begin
          phase_d    = '0;
          pend_d     = 1'b0;
          phase_open = 1'b1;
          state_d    = (pend_q || start_evt) ? ADCC_CONV : ADCC_IDLE;
        end
      end
      ADCC_CONV: begin
        // Starts during a conversion are dropped; the core cannot restart mid-way
        if (conv_end) begin
          state_d = ADCC_IDLE;
          phase_d = '0;
        end
      end
      default: begin
        state_d = ADCC_IDLE;
        pend_d  = 1'b0;
        phase_d = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Busy, flags and interrupt events
  logic       busy;
  logic       busy_fall;
  logic [2:0] irq_evt;

  // Busy covers a pending start in tracking and the conversion itself
  assign busy      = (state_q == ADCC_CONV) || pend_q;  // RL7 RL8
  assign busy_fall = busy_prev_q && !busy;  // RL9
  // Set wins over a software clear written in the same cycle
  assign done_d    = conv_end || (done_q && !(ctrl_wr &&
                     !bus_req.wdata[`ADCC_CTRL_DONE]));  // RL5 RL6
  assign win_d     = (conv_end && core_res.window_hit) || (win_q && !(ctrl_wr &&
                     !bus_req.wdata[`ADCC_CTRL_WIN]));  // RL15 RL16
  assign irq_evt   = {busy_fall, conv_end && core_res.window_hit, conv_end};
  // Reading status clears it, but an event in that cycle survives
  for (genvar i = 0; i < 3; i++) begin : g_stat
    assign irq_stat_d[i] = irq_evt[i] || (irq_stat_q[i] && !stat_rd);
  end
  // Level output, high until status is read or the mask bit drops
  assign conv_irq   = |(irq_stat_q & irq_mask_q);  // RL9

  ////////////////////////////////////////////////////////////////////////
  // Core strobes
  assign core_track   = (state_q == ADCC_TRACK) ||
                        ((state_q == ADCC_IDLE) && trk_pin_mode &&
                         !ext_conv_start_in);  // RL4
  assign core_convert = (state_q == ADCC_CONV);

  ////////////////////////////////////////////////////////////////////////
  // Read mux with result justification
  logic [7:0] ctrl_view;
  logic [7:0] res_high;
  logic [7:0] res_low;
  logic [7:0] rd_mux;
  logic [15:0] res_pair;

  assign ctrl_view = {trk_mode_q, done_q, busy, start_mode_q, win_q, ljst_q};
  assign res_pair  = justify(ljst_q, result_q);  // RL17 RL18
  assign res_high  = res_pair[15:8];
  assign res_low   = res_pair[7:0];

  always_comb begin
    unique case (bus_req.addr)
      `ADCC_OFS_CTRL:     rd_mux = ctrl_view;
      `ADCC_OFS_RES_HIGH: rd_mux = res_high;
      `ADCC_OFS_RES_LOW:  rd_mux = res_low;
      `ADCC_OFS_IRQ_STAT: rd_mux = {5'h00, irq_stat_q};
      `ADCC_OFS_IRQ_MASK: rd_mux = {5'h00, irq_mask_q};
      default:            rd_mux = 8'h00;
    endcase
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= ADCC_IDLE;
      phase_q     <= '0;
      pend_q      <= 1'b0;
      busy_prev_q <= 1'b0;
      ext_prev_q  <= 1'b1;  // Pin high at release is no edge
    end else begin
      state_q     <= state_d;
      phase_q     <= phase_d;
      pend_q      <= pend_d;
      busy_prev_q <= busy;
      ext_prev_q  <= ext_conv_start_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control fields written by software
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trk_mode_q   <= 2'(`ADCC_CTRL_RST >> `ADCC_CTRL_TRK_LO);
      start_mode_q <= 2'(`ADCC_CTRL_RST >> `ADCC_CTRL_STM_LO);
      ljst_q       <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        trk_mode_q   <= bus_req.wdata[`ADCC_CTRL_TRK_HI:`ADCC_CTRL_TRK_LO];
        start_mode_q <= bus_req.wdata[`ADCC_CTRL_STM_HI:`ADCC_CTRL_STM_LO];
        ljst_q       <= bus_req.wdata[`ADCC_CTRL_LJST];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt mask, kept apart since its write has its own offset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_q <= `ADCC_MASK_RST;
    end else if (mask_wr) begin
      irq_mask_q <= bus_req.wdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags and status
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q     <= 1'b0;
      win_q      <= 1'b0;
      irq_stat_q <= 3'h0;
    end else begin
      done_q     <= done_d;
      win_q      <= win_d;
      irq_stat_q <= irq_stat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result capture and read data
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= 10'h000;
      rdata_q  <= 8'h00;
    end else begin
      // Result holds until the next conversion ends, so a late read still sees it
      if (conv_end) begin
        result_q <= core_res.data;
      end
      // Data stand only in the cycle after the read strobe
      rdata_q <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

endmodule

// *** tb/adcc_monitor.sv ***
`include "adcc_cfg.svh"

module adcc_monitor #(
  parameter int SAR_DIV    = 4,
  parameter int TRACK_CLKS = 3,
  parameter int CONV_CLKS  = 11
) (
  // Clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst_b,
  // Register port
  input wire adcc_pkg::adcc_bus_req_s bus_req,
  input wire logic [7:0]            reg_rdata,
  // Core and interrupt
  input wire logic                  core_track,
  input wire logic                  core_convert,
  input wire logic                  conv_irq
);
  import adcc_pkg::*;
  localparam int TRK_N = TRACK_CLKS * SAR_DIV;
  localparam int CNV_N = CONV_CLKS * SAR_DIV;
  int         trk_n;
  int         cnv_n;
  logic [1:0] tmode_q;
  logic [2:0] mask_q;
  logic       done_q;
  // Shadow decode of the software writes and control reads
  wire ctrl_wr = bus_req.wr && bus_req.addr == `ADCC_OFS_CTRL;
  wire ctrl_rd = bus_req.rd && bus_req.addr == `ADCC_OFS_CTRL;
  wire mask_wr = bus_req.wr && bus_req.addr == `ADCC_OFS_IRQ_MASK;

  // Phase lengths are counted here since repetition cannot reach them
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trk_n   <= 0;
      cnv_n   <= 0;
      tmode_q <= 2'h0;
      mask_q  <= 3'h0;
      done_q  <= 1'b0;
    end else begin
      trk_n <= core_track ? trk_n + 1 : 0;
      cnv_n <= core_convert ? cnv_n + 1 : 0;
      if (ctrl_wr) tmode_q <= bus_req.wdata[7:6];
      if (mask_wr) mask_q <= bus_req.wdata[2:0];
      if ($fell(core_convert)) done_q <= 1'b1;
      else if (ctrl_wr && !bus_req.wdata[5]) done_q <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // Pin-driven tracking in mode 10 has no fixed length, so it is left out
  a_track_len: assert property ($fell(core_track) && tmode_q != 2'b10 |-> trk_n == TRK_N)
    else $error("tracking phase length wrong");
  a_conv_len: assert property ($fell(core_convert) |-> cnv_n == CNV_N)
    else $error("conversion phase length wrong");
  a_busy_conv: assert property (ctrl_rd && core_convert |=> reg_rdata[4])
    else $error("busy reads zero while converting");
  a_busy_idle: assert property (ctrl_rd && !core_convert && !core_track |=> !reg_rdata[4])
    else $error("busy reads one while idle");
  a_done_held: assert property (ctrl_rd && done_q |=> reg_rdata[5])
    else $error("done flag lost before clear");
  a_irq_end: assert property ($fell(core_convert) && mask_q[2] |-> ##[0:2] conv_irq)
    else $error("no interrupt after busy fell");
  a_irq_quiet: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !conv_irq)
    else $error("interrupt while fully masked");
  a_rdata_idle: assert property (!bus_req.rd |=> reg_rdata == 8'h00)
    else $error("read data outside read answer");
  a_unmapped_zero: assert property (bus_req.rd && bus_req.addr > 3'h4 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind adcc_ctrl adcc_monitor #(
  .SAR_DIV(SAR_DIV), .TRACK_CLKS(TRACK_CLKS), .CONV_CLKS(CONV_CLKS)
) u_mon (
  .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .reg_rdata(reg_rdata),
  .core_track(core_track), .core_convert(core_convert), .conv_irq(conv_irq)
);

// *** tb/adcc_ctrl_tb.sv ***
module adcc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import adcc_pkg::*;
  localparam int SDIV = 4;
  localparam int TRK  = 3 * SDIV;
  localparam int CNV  = 11 * SDIV;
  logic           ref_clk, rst_b, tmr2_ovf, tmr3_ovf, ext_conv_start_in;
  logic           core_track, core_convert, conv_irq;
  logic [7:0]     reg_rdata;
  adcc_bus_req_s  bus_req;
  adcc_core_res_s core_res;
  int             error_cnt, n_compared, nt, nc;

  adcc_ctrl #(.SAR_DIV(SDIV)) uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .reg_rdata(reg_rdata),
    .tmr2_ovf(tmr2_ovf), .tmr3_ovf(tmr3_ovf), .ext_conv_start_in(ext_conv_start_in),
    .core_res(core_res), .core_track(core_track), .core_convert(core_convert),
    .conv_irq(conv_irq)
  );

  // Free-running 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe, so sample just there
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 chk_byte(reg_rdata, exp);
  endtask
  task automatic pulse_tmr(input bit t2);
    @(posedge ref_clk);
    if (t2) tmr2_ovf <= 1'b1;
    else tmr3_ovf <= 1'b1;
    @(posedge ref_clk);
    tmr2_ovf <= 1'b0;
    tmr3_ovf <= 1'b0;
  endtask
  // Counts track and convert cycles; bounded so a dead start cannot hang
  task automatic measure();
    int w;
    w  = 0;
    nt = 0;
    nc = 0;
    #1;
    while (!(core_track || core_convert) && w < 20) begin
      @(posedge ref_clk);
      #1 w++;
    end
    while (core_track === 1'b1 && nt < 500) begin
      nt++;
      @(posedge ref_clk);
      #1;
    end
    while (core_convert === 1'b1 && nc < 500) begin
      nc++;
      @(posedge ref_clk);
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_rd(3'h0, 8'h00);
    chk_rd(3'h4, 8'h00);
    chk_rd(3'h6, 8'h00);
    chk_byte({7'h00, conv_irq}, 8'h00);
  endtask
  task automatic t_sw_conv();
    @(posedge ref_clk);
    core_res <= '{data: 10'h2A5, window_hit: 1'b1};
    wr_reg(3'h0, 8'h10);
    measure();
    chk_cnt(nt, TRK);
    chk_cnt(nc, CNV);
    repeat (2) @(posedge ref_clk);
    #1 chk_byte({7'h00, conv_irq}, 8'h00);
    chk_rd(3'h0, 8'h22);
    chk_rd(3'h0, 8'h22);
    chk_rd(3'h1, 8'h02);
    chk_rd(3'h2, 8'hA5);
    chk_rd(3'h3, 8'h07);
    chk_rd(3'h3, 8'h00);
  endtask
  task automatic t_no_start();
    wr_reg(3'h0, 8'h00);
    chk_rd(3'h0, 8'h00);
    wr_reg(3'h0, 8'h54);
    measure();
    chk_cnt(nt + nc, 0);
  endtask
  // Tracking mode 00 beside another start mode: a busy write tracks, then idles
  task automatic t_track_only();
    wr_reg(3'h0, 8'h14);
    measure();
    chk_cnt(nt, TRK);
    chk_cnt(nc, 0);
    chk_rd(3'h0, 8'h04);
  endtask
  task automatic t_tmr3_irq();
    wr_reg(3'h4, 8'h04);
    chk_rd(3'h4, 8'h04);
    wr_reg(3'h0, 8'h44);
    pulse_tmr(1'b0);
    measure();
    chk_cnt(nt, TRK);
    chk_cnt(nc, CNV);
    repeat (2) @(posedge ref_clk);
    #1 chk_byte({7'h00, conv_irq}, 8'h01);
    chk_rd(3'h3, 8'h07);
    @(posedge ref_clk);
    #1 chk_byte({7'h00, conv_irq}, 8'h00);
  endtask
  task automatic t_tmr2_left();
    wr_reg(3'h0, 8'hCD);
    pulse_tmr(1'b1);
    measure();
    chk_cnt(nt, TRK);
    chk_cnt(nc, CNV);
    chk_rd(3'h0, 8'hEF);
    chk_rd(3'h1, 8'hA9);
    chk_rd(3'h2, 8'h40);
  endtask
  // Pin mode has no tracking timer: the pin level itself is the tracking window
  task automatic t_ext();
    @(posedge ref_clk);
    core_res <= '{data: 10'h155, window_hit: 1'b0};
    wr_reg(3'h0, 8'h88);
    ext_conv_start_in <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk_byte({7'h00, core_track}, 8'h01);
    @(posedge ref_clk);
    ext_conv_start_in <= 1'b1;
    measure();
    chk_cnt(nt, 0);
    chk_cnt(nc, CNV);
    chk_rd(3'h0, 8'hA8);
    chk_rd(3'h1, 8'h01);
    chk_rd(3'h2, 8'h55);
  endtask
  task automatic t_busy_read();
    wr_reg(3'h0, 8'h10);
    repeat (20) @(posedge ref_clk);
    chk_rd(3'h0, 8'h10);
    measure();
  endtask

  task automatic print_verdict();
    $display("errors %0d, compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Whole run is under a thousand cycles; this cuts a hang
  initial begin
    #250000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst_b = 1'b0;
    bus_req = '0;
    core_res = '0;
    tmr2_ovf = 1'b0;
    tmr3_ovf = 1'b0;
    ext_conv_start_in = 1'b1;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_sw_conv();
    t_no_start();
    t_track_only();
    t_tmr3_irq();
    t_tmr2_left();
    t_ext();
    t_busy_read();
    print_verdict();
  end
endmodule
